// file: lirq_pkg.sv
// Shared constants, types and the overview for the local interrupt block
// Overview of operation
// - A completion write clears the top in-service bit, then dispatches next.
// - Completing a level-triggered vector broadcasts a completion message on the bus unless one is already waiting.
// - Threshold N blocks priority classes N and below; 0 admits classes 1 to 15, 15 none.
// - The task priority threshold resets to zero.
// - A control-register threshold write takes effect as the write completes.
// - Control-register access from nonzero privilege raises protection fault zero.
// - Only bits 3:0 of the control register hold; nonzero upper bits fault.
// - Controller comes up enabled; control writes act and mirror only while enabled.
// - Control write loads threshold bits 7:4, clears 3:0; read zero-extends 7:4.
// - Acknowledge of a newly masked request returns the spurious vector, state untouched.
// - Spurious vector: newer parts all 8 bits writable; older bits 3:0 hardwired ones.
// - Software-enable bit set enables the controller, cleared disables it.
// - Older parts: focus-check bit 0 enables, 1 disables; newer reserve it. Here bit 9 is only stored (older) or cleared (newer); no logic reads it.
// - Contenders send type and priority first; losers stop; the survivor sends.
// - After a message all add one, sender goes to 0, idle 15 takes sender+1.
// - Completion messages win regardless of priority; among them priority decides.
// - Lowest-priority ties break by arbitration identifier using all 8 priority bits.
package lirq_pkg;
  localparam int VEC_W = 8;
  localparam int NVEC = 256;
  localparam int PRI_W = 4;
  localparam int CR8_W = 64;
  localparam int SVR_W = 32;
  localparam int SVR_EN_BIT = 8;
  localparam int SVR_FOCUS_BIT = 9;
  localparam logic [31:0] SVR_RESET = 32'h000001FF;
  localparam logic [7:0] TPR_RESET = 8'h00;
  localparam logic [3:0] VEC_LOW_HARD = 4'hF;
  localparam logic [3:0] PRI_TOP = 4'hF;
  localparam logic [3:0] PRI_ONE = 4'h1;
  localparam logic [4:0] HDR_LAST = 5'h04;
  localparam logic [4:0] MSG_LAST = 5'h07;
  localparam logic [1:0] CPL_KERNEL = 2'h0;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_CONTEND = 2'b01,
    ARB_SEND = 2'b11,
    ARB_LISTEN = 2'b10
  } arb_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] cpl;
    logic [CR8_W-1:0] wdata;
  } cr8_req_t;

  typedef struct packed {
    logic valid;
    logic level;
    logic [VEC_W-1:0] vector;
  } accept_t;
endpackage

// file: lirq_core.sv
// Completion, threshold, spurious vector and serial bus arbitration logic
`timescale 1ns/100ps
`default_nettype none
module lirq_core (
  input wire logic clk, // 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire lirq_pkg::accept_t accept, // Accepted fixed interrupt
  input wire logic ack_cycle, // Acknowledge cycle pulse from core
  input wire logic completion_wr, // Completion register write pulse
  input wire lirq_pkg::cr8_req_t cr8_req, // Priority control access
  input wire logic tpr_wr, // Memory-mapped threshold write
  input wire logic [7:0] tpr_wdata, // Memory-mapped threshold data
  input wire logic svr_wr, // Spurious vector register write
  input wire logic [31:0] svr_wdata, // Spurious vector register data
  input wire logic legacy_mode, // Strap: older register layout
  input wire logic [3:0] arbitration_identifier, // Unique bus id
  input wire logic [7:0] peer_lp_value, // Peer lowest-priority value
  input wire logic [3:0] peer_arbitration_identifier, // Peer arbitration id
  input wire logic bus_tick, // Serial bus bit clock pin
  input wire logic bus_line_i, // Serial bus level
  output logic bus_line_o, // Serial bus drive value
  output logic bus_line_oe, // Serial bus drive enable
  output logic core_request_line, // Interrupt request to core
  output logic ack_valid, // Vector answer valid pulse
  output logic [7:0] ack_vector, // Delivered vector
  output logic [7:0] tpr_rdata, // Memory-mapped threshold readback
  output logic [31:0] svr_rdata, // Spurious vector register readback
  output logic [63:0] cr8_rdata, // Control register read data
  output logic cr8_done, // Control access completed pulse
  output logic cr8_fault, // Protection fault zero pulse
  output logic eoi_msg_sent, // Completion message sent pulse
  output logic [3:0] arb_priority, // Current bus arbitration priority
  output logic lp_win // This controller wins lowest-priority tie
);
  logic [255:0] irr_q, irr_d, isr_q, isr_d, tmr_q, tmr_d;
  logic [7:0] tpr_q, tpr_d;
  logic [31:0] svr_q, svr_d;
  logic [63:0] cr8_rdata_q, cr8_rdata_d;
  logic cr8_done_q, cr8_fault_q;
  logic req_q, ack_valid_q;
  logic [7:0] ack_vector_q, ack_vector_d;
  logic [2:0] legacy_sync_q, tick_sync_q;
  logic [1:0] line_sync_q;
  logic legacy_q;
  logic [1:0] id_load_q;
  logic [3:0] apr_q, apr_d;
  logic pend_q, pend_d;
  logic [7:0] pend_vec_q, pend_vec_d;
  lirq_pkg::arb_state_t st_q, st_d;
  logic [4:0] bit_q, bit_d;
  logic contend_q, contend_d;
  logic [3:0] obs_q, obs_d;
  logic oe_q, oe_d, sent_q, lp_win_q;

  function automatic logic [8:0] top_bit(input logic [255:0] v);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 0; i < 256; i++) begin
      if (v[i]) begin
        r = {1'b1, 8'(i)};
      end
    end
    return r;
  endfunction

  // Highest set request and in-service vectors, bit 8 flags presence
  wire [8:0] irr_top = top_bit(irr_q);
  wire [8:0] isr_top = top_bit(isr_q);
  wire enabled = svr_q[lirq_pkg::SVR_EN_BIT];
  wire [3:0] isr_cls = isr_top[8] ? isr_top[7:4] : 4'h0;
  wire [3:0] ppr_cls = (tpr_q[7:4] >= isr_cls) ? tpr_q[7:4] : isr_cls;
  // Class must exceed both threshold and in-service class
  wire deliverable = enabled && irr_top[8] &&
    (irr_top[7:4] > ppr_cls);
  wire [7:0] spur_vec = legacy_q ?
    {svr_q[7:4], lirq_pkg::VEC_LOW_HARD} : svr_q[7:0];

  // Control register checks
  wire cr8_any = cr8_req.wr | cr8_req.rd;
  wire cr8_bad_cpl = cr8_req.cpl != lirq_pkg::CPL_KERNEL;
  wire cr8_bad_hi = cr8_req.wr && (cr8_req.wdata[63:4] != 60'h0);
  wire cr8_flt = cr8_any && (cr8_bad_cpl || cr8_bad_hi);
  wire cr8_wr_ok = cr8_req.wr && !cr8_flt && enabled;
  wire cr8_rd_ok = cr8_req.rd && !cr8_flt;

  // Completion handling
  wire do_eoi = completion_wr && isr_top[8];
  wire eoi_level = do_eoi && tmr_q[isr_top[7:0]];
  wire do_ack = ack_cycle;

  // Serial bus sampled levels: line uses the second stage, tick edge the second and third
  wire tick_rise = tick_sync_q[1] & ~tick_sync_q[2];
  wire line_s = line_sync_q[1];
  wire [4:0] hdr = {1'b1, apr_q}; // Completion type bit leads

  always_comb begin
    irr_d = irr_q;
    isr_d = isr_q;
    tmr_d = tmr_q;
    ack_vector_d = ack_vector_q;
    if (do_eoi) begin
      isr_d[isr_top[7:0]] = 1'b0;
    end
    if (do_ack && deliverable) begin
      irr_d[irr_top[7:0]] = 1'b0;
      isr_d[irr_top[7:0]] = 1'b1;
      ack_vector_d = irr_top[7:0];
    end else if (do_ack) begin
      ack_vector_d = spur_vec;
    end
    // A new acceptance wins over a same-cycle dispatch clear
    if (accept.valid) begin
      irr_d[accept.vector] = 1'b1;
      tmr_d[accept.vector] = accept.level;
    end
  end

  always_comb begin
    tpr_d = tpr_q;
    svr_d = svr_q;
    cr8_rdata_d = cr8_rdata_q;
    if (tpr_wr) begin
      tpr_d = tpr_wdata;
    end
    if (cr8_wr_ok) begin
      tpr_d = {cr8_req.wdata[3:0], 4'h0};
    end
    if (cr8_rd_ok) begin
      cr8_rdata_d = {60'h0, tpr_q[7:4]};
    end
    if (svr_wr) begin
      svr_d = {22'h0, svr_wdata[9:0]};
      if (legacy_q) begin
        svr_d[3:0] = lirq_pkg::VEC_LOW_HARD;
      end else begin
        svr_d[lirq_pkg::SVR_FOCUS_BIT] = 1'b0;
      end
    end
  end

  // Bus arbitration and message sequencing
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    contend_d = contend_q;
    obs_d = obs_q;
    apr_d = apr_q;
    pend_d = pend_q;
    pend_vec_d = pend_vec_q;
    oe_d = 1'b0;
    case (st_q)
      lirq_pkg::ARB_IDLE: begin
        oe_d = pend_q;
        if (tick_rise && (pend_q || line_s)) begin
          st_d = lirq_pkg::ARB_CONTEND;
          bit_d = 5'h00;
          contend_d = pend_q;
        end
      end
      lirq_pkg::ARB_CONTEND: begin
        oe_d = contend_q && hdr[3'(3'd4 - bit_q[2:0])];
        if (tick_rise) begin
          if (contend_q && !hdr[3'(3'd4 - bit_q[2:0])] && line_s) begin
            contend_d = 1'b0;
          end
          if (bit_q != 5'h00) begin
            obs_d = {obs_q[2:0], line_s};
          end
          bit_d = bit_q + 5'h01;
          if (bit_q == lirq_pkg::HDR_LAST) begin
            bit_d = 5'h00;
            st_d = contend_d ? lirq_pkg::ARB_SEND : lirq_pkg::ARB_LISTEN;
          end
        end
      end
      lirq_pkg::ARB_SEND, lirq_pkg::ARB_LISTEN: begin
        oe_d = (st_q == lirq_pkg::ARB_SEND) &&
          pend_vec_q[3'(3'd7 - bit_q[2:0])];
        if (tick_rise) begin
          bit_d = bit_q + 5'h01;
          if (bit_q == lirq_pkg::MSG_LAST) begin
            st_d = lirq_pkg::ARB_IDLE;
            if (st_q == lirq_pkg::ARB_SEND) begin
              apr_d = 4'h0;
              pend_d = 1'b0;
            end else if (apr_q == lirq_pkg::PRI_TOP) begin
              apr_d = obs_q + lirq_pkg::PRI_ONE;
            end else begin
              apr_d = apr_q + lirq_pkg::PRI_ONE;
            end
          end
        end
      end
      default: begin
        st_d = lirq_pkg::ARB_IDLE;
      end
    endcase
    // A new completion is queued only when none is waiting
    if (eoi_level && !pend_q) begin
      pend_d = 1'b1;
      pend_vec_d = isr_top[7:0];
    end
  end

  // Lowest-priority tie break over the full 8-bit value
  wire [7:0] own_lp = tpr_q;
  wire lp_win_d = (own_lp < peer_lp_value) ||
    ((own_lp == peer_lp_value) &&
    (arbitration_identifier > peer_arbitration_identifier));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      legacy_sync_q <= 3'h0;
      tick_sync_q <= 3'h0;
      line_sync_q <= 2'h0;
    end else begin
      legacy_sync_q <= {legacy_sync_q[1:0], legacy_mode};
      tick_sync_q <= {tick_sync_q[1:0], bus_tick};
      line_sync_q <= {line_sync_q[0], bus_line_i};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irr_q <= '0;
      isr_q <= '0;
      tmr_q <= '0;
      tpr_q <= lirq_pkg::TPR_RESET;
      svr_q <= lirq_pkg::SVR_RESET;
    end else begin
      irr_q <= irr_d;
      isr_q <= isr_d;
      tmr_q <= tmr_d;
      tpr_q <= tpr_d;
      svr_q <= svr_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cr8_rdata_q <= '0;
      cr8_done_q <= 1'b0;
      cr8_fault_q <= 1'b0;
      req_q <= 1'b0;
      ack_valid_q <= 1'b0;
      ack_vector_q <= 8'h00;
    end else begin
      cr8_rdata_q <= cr8_rdata_d;
      cr8_done_q <= cr8_any && !cr8_flt;
      cr8_fault_q <= cr8_flt;
      req_q <= deliverable && !do_ack;
      ack_valid_q <= do_ack;
      ack_vector_q <= ack_vector_d;
    end
  end

  // Strap and identifier are caught after reset release, not under it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      legacy_q <= 1'b0;
      id_load_q <= 2'h0;
      apr_q <= 4'h0;
      st_q <= lirq_pkg::ARB_IDLE;
      bit_q <= 5'h00;
      contend_q <= 1'b0;
      obs_q <= 4'h0;
      pend_q <= 1'b0;
      pend_vec_q <= 8'h00;
      oe_q <= 1'b0;
      sent_q <= 1'b0;
      lp_win_q <= 1'b0;
    end else begin
      legacy_q <= legacy_sync_q[2];
      id_load_q <= {id_load_q[0], 1'b1};
      apr_q <= (id_load_q == 2'h1) ? arbitration_identifier : apr_d;
      st_q <= st_d;
      bit_q <= bit_d;
      contend_q <= contend_d;
      obs_q <= obs_d;
      pend_q <= pend_d;
      pend_vec_q <= pend_vec_d;
      oe_q <= oe_d;
      sent_q <= (st_q == lirq_pkg::ARB_SEND) && (st_d == lirq_pkg::ARB_IDLE);
      lp_win_q <= lp_win_d;
    end
  end

  assign bus_line_o = oe_q;
  assign bus_line_oe = oe_q;
  assign core_request_line = req_q;
  assign ack_valid = ack_valid_q;
  assign ack_vector = ack_vector_q;
  assign tpr_rdata = tpr_q;
  assign svr_rdata = svr_q;
  assign cr8_rdata = cr8_rdata_q;
  assign cr8_done = cr8_done_q;
  assign cr8_fault = cr8_fault_q;
  assign eoi_msg_sent = sent_q;
  assign arb_priority = apr_q;
  assign lp_win = lp_win_q;
endmodule
`default_nettype wire

// file: lirq_core_sva.sv
// Port-level assertion checker for the local interrupt block
`timescale 1ns/100ps
`default_nettype none
module lirq_core_sva (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic ack_cycle, // Acknowledge pulse
  input wire lirq_pkg::cr8_req_t cr8_req, // Control access
  input wire logic tpr_wr, // Threshold write
  input wire logic ack_valid, // Answer valid
  input wire logic [7:0] ack_vector, // Answer vector
  input wire logic [7:0] tpr_rdata, // Threshold view
  input wire logic [31:0] svr_rdata, // Spurious register view
  input wire logic [63:0] cr8_rdata, // Control read data
  input wire logic cr8_done, // Access done
  input wire logic cr8_fault, // Access fault
  input wire logic eoi_msg_sent, // Completion message sent
  input wire logic [3:0] arb_priority // Bus priority
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic acc = cr8_req.wr | cr8_req.rd;
  wire logic bad = (cr8_req.cpl != 2'h0) | (cr8_req.wr & |cr8_req.wdata[63:4]);
  a_ack_answer: assert property (ack_cycle |=> ack_valid)
    else $error("no vector answer after acknowledge");
  a_cr8_fault: assert property (acc && bad |=> cr8_fault && !cr8_done)
    else $error("illegal control access not faulted");
  a_cr8_accept: assert property (acc && !bad |=> cr8_done && !cr8_fault)
    else $error("legal control access not completed");
  a_cr8_mirror: assert property (cr8_req.wr && !bad && svr_rdata[8]
    |=> tpr_rdata == {$past(cr8_req.wdata[3:0]), 4'h0})
    else $error("control write not mirrored into threshold");
  a_cr8_keep: assert property (cr8_req.wr && (bad || !svr_rdata[8]) && !tpr_wr
    |=> $stable(tpr_rdata))
    else $error("refused control write changed threshold");
  a_cr8_read: assert property (cr8_req.rd && !bad
    |=> cr8_rdata == {60'h0, $past(tpr_rdata[7:4])})
    else $error("control read data wrong");
  a_spur_off: assert property (ack_cycle && !svr_rdata[8]
    |=> ack_vector == $past(svr_rdata[7:0]))
    else $error("disabled controller gave a non-spurious vector");
  a_sender_zero: assert property (eoi_msg_sent |-> ##[0:2] arb_priority == 4'h0)
    else $error("sender priority not dropped to zero");
  a_svr_upper: assert property (svr_rdata[31:10] == 22'h0)
    else $error("spurious register upper bits not zero");
endmodule
bind lirq_core lirq_core_sva u_sva (.clk, .rst_n, .ack_cycle, .cr8_req, .tpr_wr,
  .ack_valid, .ack_vector, .tpr_rdata, .svr_rdata, .cr8_rdata, .cr8_done,
  .cr8_fault, .eoi_msg_sent, .arb_priority);
`default_nettype wire

// file: lirq_bus_peer.sv
// Serial bus peer: makes the frame bit clock and resolves the wired-OR line
`timescale 1ns/100ps
`default_nettype none
module lirq_bus_peer #(
  parameter int HALF = 4 // Clocks per half bit period
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic dut_o, // Block drive value
  input wire logic dut_oe, // Block drive enable
  output logic tick, // Bus bit clock
  output logic line // Resolved bus level
);
  int cnt;
  // Peer never contends, so it stays released and the pull-down holds 0
  assign line = dut_oe & dut_o;
  // Clock stands still between frames; 14 bits make one frame
  assign tick = (cnt != 0) && ((cnt - 1) % (2 * HALF)) < HALF;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
    end else if (cnt != 0 || line) begin
      cnt <= (cnt == 14 * 2 * HALF) ? 0 : cnt + 1;
    end
  end
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the local interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  lirq_pkg::accept_t accept = '0;
  lirq_pkg::cr8_req_t cr8_req = '0;
  logic ack_cycle = 1'h0, completion_wr = 1'h0, tpr_wr = 1'h0, svr_wr = 1'h0;
  logic legacy_mode = 1'h0;
  logic [7:0] tpr_wdata = 8'h00, peer_lp_value = 8'h00;
  logic [31:0] svr_wdata = 32'h0;
  logic [3:0] arbitration_identifier = 4'h5, peer_arbitration_identifier = 4'h0;
  logic bus_tick, bus_line_i, bus_line_o, bus_line_oe, core_request_line;
  logic ack_valid, cr8_done, cr8_fault, eoi_msg_sent, lp_win;
  logic [7:0] ack_vector, tpr_rdata, v;
  logic [31:0] svr_rdata, d;
  logic [63:0] cr8_rdata;
  logic [3:0] arb_priority, w;
  int seed = 93027, bad_count = 0, comparisons = 0, cycles = 0;
  always #5 clk = ~clk;
  lirq_core u_dut (.clk, .rst_n, .accept, .ack_cycle, .completion_wr, .cr8_req,
    .tpr_wr, .tpr_wdata, .svr_wr, .svr_wdata, .legacy_mode,
    .arbitration_identifier, .peer_lp_value, .peer_arbitration_identifier, .bus_tick,
    .bus_line_i, .bus_line_o, .bus_line_oe, .core_request_line, .ack_valid,
    .ack_vector, .tpr_rdata, .svr_rdata, .cr8_rdata, .cr8_done, .cr8_fault,
    .eoi_msg_sent, .arb_priority, .lp_win);
  lirq_bus_peer #(.HALF(4)) u_peer (.clk, .rst_n, .dut_o(bus_line_o),
    .dut_oe(bus_line_oe), .tick(bus_tick), .line(bus_line_i));
  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Peer tie rule over the full 8-bit value, ties to the higher identifier
  function automatic logic exp_lp(input logic [7:0] own);
    return (own < peer_lp_value) ||
      ((own == peer_lp_value) && (arbitration_identifier > peer_arbitration_identifier));
  endfunction
  task automatic cr8(input logic wr, input logic [1:0] cpl, input logic [63:0] x);
    @(posedge clk);
    cr8_req <= '{wr: wr, rd: !wr, cpl: cpl, wdata: x};
    @(posedge clk);
    cr8_req <= '0;
    #1;
  endtask
  task automatic spurious_vector_config(input logic [31:0] x);
    @(posedge clk);
    svr_wr <= 1'h1;
    svr_wdata <= x;
    @(posedge clk);
    svr_wr <= 1'h0;
    #1;
  endtask
  task automatic raise(input logic [7:0] x, input logic lvl);
    @(posedge clk);
    accept <= '{valid: 1'h1, level: lvl, vector: x};
    @(posedge clk);
    accept <= '0;
    for (int i = 0; i < 20 && core_request_line !== 1'h1; i++) @(negedge clk);
    chk(core_request_line, 1'h1);
  endtask
  task automatic ack(input logic [7:0] exp);
    @(posedge clk);
    ack_cycle <= 1'h1;
    @(posedge clk);
    ack_cycle <= 1'h0;
    #1;
    chk({ack_valid, ack_vector}, {1'h1, exp});
  endtask
  task automatic completion_register();
    @(posedge clk);
    completion_wr <= 1'h1;
    @(posedge clk);
    completion_wr <= 1'h0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk(svr_rdata, 32'h1FF);
    chk(tpr_rdata, 8'h00);
    chk(arb_priority, 4'h5);
    $display("Test reset done");
    repeat (8) begin
      w = 4'($random(seed));
      peer_lp_value <= 8'($random(seed));
      peer_arbitration_identifier <= 4'($random(seed));
      cr8(1'h1, 2'h0, {60'h0, w});
      chk(tpr_rdata, {w, 4'h0});
      cr8(1'h0, 2'h0, 64'h0);
      chk(cr8_rdata, {60'h0, w});
      chk(lp_win, exp_lp({w, 4'h0}));
      cr8(w[0], w[2:1] | 2'h1, 64'h0);
      chk(cr8_fault, 1'h1);
      cr8(1'h1, 2'h0, {32'($random(seed)) | 32'h1, 28'h0, ~w});
      chk({cr8_fault, tpr_rdata}, {1'h1, w, 4'h0});
    end
    $display("Test control register done");
    cr8(1'h1, 2'h0, 64'h0);
    repeat (6) begin
      v = (8'($random(seed)) | 8'h20) & 8'hFE;
      raise(v, 1'h0);
      cr8(1'h1, 2'h0, {60'h0, v[7:4]});
      ack(8'hFF);
      cr8(1'h1, 2'h0, {60'h0, v[7:4] - 4'h1});
      raise(v, 1'h0);
      ack(v);
      completion_register();
      cr8(1'h1, 2'h0, 64'h0);
    end
    raise(8'h31, 1'h0);
    raise(8'h52, 1'h0);
    ack(8'h52);
    completion_register();
    raise(8'h31, 1'h0);
    ack(8'h31);
    completion_register();
    $display("Test delivery done");
    @(posedge clk);
    tpr_wr <= 1'h1;
    tpr_wdata <= 8'hA7;
    peer_lp_value <= 8'hA7;
    peer_arbitration_identifier <= 4'h3;
    @(posedge clk);
    tpr_wr <= 1'h0;
    cr8(1'h0, 2'h0, 64'h0);
    chk(tpr_rdata, 8'hA7);
    chk(cr8_rdata, 64'hA);
    chk(lp_win, exp_lp(8'hA7));
    d = 32'($random(seed)) | 32'h300;
    spurious_vector_config(d);
    chk(svr_rdata, {22'h0, 2'h1, d[7:0]});
    spurious_vector_config(32'h0);
    cr8(1'h1, 2'h0, 64'h3);
    chk({cr8_done, tpr_rdata}, {1'h1, 8'hA7});
    ack(8'h00);
    spurious_vector_config(32'h1FF);
    legacy_mode <= 1'h1;
    repeat (5) @(posedge clk);
    spurious_vector_config(32'h35A);
    chk(svr_rdata, 32'h35F);
    ack(8'h5F);
    legacy_mode <= 1'h0;
    repeat (5) @(posedge clk);
    spurious_vector_config(32'h1FF);
    $display("Test spurious register done");
    cr8(1'h1, 2'h0, 64'h0);
    raise(8'h61, 1'h1);
    ack(8'h61);
    completion_register();
    repeat (2) @(posedge clk);
    #1;
    chk({bus_line_oe, bus_line_o}, 2'h3);
    for (int i = 0; i < 400 && eoi_msg_sent !== 1'h1; i++) @(negedge clk);
    chk(eoi_msg_sent, 1'h1);
    repeat (3) @(posedge clk);
    #1;
    chk(arb_priority, 4'h0);
    $display("Test completion message done");
    finish_test();
  end
endmodule
`default_nettype wire
